// ===== verilog/dmaef_pkg.sv
// Purpose: shared constants and types of the DMA channel event flag block
// Assumes: 32-bit Avalon-MM register bus with byte addresses
// Notes:   offsets are byte addresses of aligned 32-bit words

`default_nettype none

package dmaef_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_CLR    = 5'h04;
    localparam logic [4:0] OFF_SET    = 5'h08;
    localparam logic [4:0] OFF_INV    = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;
    localparam logic [4:0] OFF_ICLR   = 5'h14;
    localparam logic [4:0] OFF_IEN    = 5'h18;

    // ************************************************************
    // field layout of the channel event control word
    // ************************************************************
    localparam int FLAG_LSB = 0;
    localparam int IE_LSB   = 16;
    localparam int FIELD_W  = 8;

    // bit index inside either byte field
    localparam int BIT_SRC_DONE   = 7;
    localparam int BIT_SRC_HALF   = 6;
    localparam int BIT_DST_DONE   = 5;
    localparam int BIT_DST_HALF   = 4;
    localparam int BIT_BLOCK_DONE = 3;
    localparam int BIT_CELL_DONE  = 2;
    localparam int BIT_ABORT      = 1;
    localparam int BIT_ADDR_ERR   = 0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [7:0]  RST_IE    = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        DMAEF_OP_WRITE = 2'b00,
        DMAEF_OP_CLR   = 2'b01,
        DMAEF_OP_SET   = 2'b11,
        DMAEF_OP_INV   = 2'b10
    } dmaef_op_e;

    // one-cycle strobes from the transfer logic of the channel
    typedef struct packed {
        logic dst_done;
        logic dst_half;
        logic block_done;
        logic cell_done;
        logic abort;
        logic addr_err;
    } dmaef_evt_s;

    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } dmaef_req_s;

endpackage : dmaef_pkg

`default_nettype wire

// ===== verilog/dmaef_top.sv
// Purpose: event flags, enables and interrupt request of one DMA channel
// Assumes: source pointer, size and event strobes come from logic on sys_clk_i
// Notes:   registers reached over Avalon-MM with waitrequest
//          every request is answered after one wait cycle
//          waitrequest stands high while the bus is idle
//          0x00 control word: enables in 23:16, flags in 7:0
//          0x04, 0x08, 0x0C clear, set and invert the control word
//          0x10 status: flags in 7:0, read only
//          0x14 flag clear: ones written clear flags, reads zero
//          0x18 enables alone in 7:0
//          unmapped words read zero and ignore writes
//          enables and flags reset to zero
//          half size is the size shifted right once, rounded down
//          a strobe held high re-sets its flag on every cycle
//          an event wins over a clear of its flag in the same cycle
//
// Overview of operation
// - bits 23:16 enable each event's interrupt
// - source done flag when pointer equals size
// - source half flag when pointer equals half size
// - flags in bits 7:0, zero means idle
// - fixed enable positions for remaining six events
// - bits 31:24 and 15:8 read zero
// - destination half full has separate enable
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module dmaef_top #(
    parameter int SIZE_W = 16
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 srst_i,
    input  wire logic [4:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output var  logic [31:0]          avs_readdata_o,
    output var  logic                 avs_waitrequest_o,
    input  wire logic [SIZE_W-1:0]    source_pointer_i,
    input  wire logic [SIZE_W-1:0]    source_size_i,
    input  wire dmaef_pkg::dmaef_evt_s evt_i,
    output var  logic                 irq_o
);

    // ************************************************************
    // functions
    // ************************************************************

    // one byte field after a write of the given kind
    function automatic logic [7:0] apply_op(
        input logic [7:0]           old_val,
        input logic [7:0]           wval,
        input dmaef_pkg::dmaef_op_e op
    );
        logic [7:0] res;
        res = old_val;
        unique case (op)
            dmaef_pkg::DMAEF_OP_WRITE: res = wval;
            dmaef_pkg::DMAEF_OP_CLR:   res = old_val & ~wval;
            dmaef_pkg::DMAEF_OP_SET:   res = old_val | wval;
            dmaef_pkg::DMAEF_OP_INV:   res = old_val ^ wval;
        endcase
        return res;
    endfunction : apply_op

    // the whole control word as software sees it
    function automatic logic [31:0] pack_ctrl(
        input logic [7:0] ie,
        input logic [7:0] flags
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[dmaef_pkg::IE_LSB   +: dmaef_pkg::FIELD_W] = ie;
        w[dmaef_pkg::FLAG_LSB +: dmaef_pkg::FIELD_W] = flags;
        return w;
    endfunction : pack_ctrl

    // a compare counts only on the cycle it becomes true
    function automatic logic match_rise(
        input logic hit,
        input logic seen
    );
        return hit & ~seen;
    endfunction : match_rise

    // a byte field shown alone in the low byte of a word
    function automatic logic [31:0] low_word(
        input logic [7:0] field
    );
        return {24'h00_0000, field};
    endfunction : low_word

    // one event's interrupt term: its flag and its enable both set
    function automatic logic armed(
        input logic [7:0] f,
        input logic [7:0] e,
        input int         b
    );
        return f[b] & e[b];
    endfunction : armed

    // ************************************************************
    // state
    // ************************************************************
    dmaef_pkg::dmaef_req_s req;
    logic [7:0]            flags;
    logic [7:0]            ie;
    logic [7:0]            next_flags;
    logic [7:0]            next_ie;
    logic [7:0]            hw_set;
    logic                  src_done_hit;
    logic                  src_half_hit;
    logic                  src_done_seen;
    logic                  src_half_seen;
    logic                  bus_req;
    logic                  wr_take;
    logic                  rd_latch;
    logic                  ctrl_hit;
    logic                  ie_lane;
    logic                  flag_lane;
    dmaef_pkg::dmaef_op_e  op;
    logic [7:0]            w_ie;
    logic [7:0]            w_flag;
    logic [31:0]           rd_value;
    logic                  src_done_evt;
    logic                  src_half_evt;
    logic                  src_done_pend;
    logic                  src_half_pend;
    logic                  dst_done_pend;
    logic                  dst_half_pend;
    logic                  block_complete_pend;
    logic                  cell_complete_pend;
    logic                  abort_pend;
    logic                  addr_error_pend;

    assign req.address    = avs_address_i;
    assign req.read       = avs_read_i;
    assign req.write      = avs_write_i;
    assign req.writedata  = avs_writedata_i;
    assign req.byteenable = avs_byteenable_i;

    // ************************************************************
    // bus handshake
    // ************************************************************

    // one wait cycle: read data is captured on the same edge where waitrequest falls,
    // so it stands at the edge where the master takes it
    assign bus_req  = req.read | req.write;
    assign rd_latch = req.read & avs_waitrequest_o;
    assign wr_take  = req.write & ~avs_waitrequest_o;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (req.address)
            dmaef_pkg::OFF_CTRL:   rd_value = pack_ctrl(ie, flags);
            dmaef_pkg::OFF_CLR:    rd_value = pack_ctrl(ie, flags);
            dmaef_pkg::OFF_SET:    rd_value = pack_ctrl(ie, flags);
            dmaef_pkg::OFF_INV:    rd_value = pack_ctrl(ie, flags);
            dmaef_pkg::OFF_STATUS: rd_value = low_word(flags);
            dmaef_pkg::OFF_IEN:    rd_value = low_word(ie);
            default:               rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= dmaef_pkg::RST_RDATA;
        end else if (rd_latch) begin
            avs_readdata_o <= rd_value;
        end
    end

    // ************************************************************
    // write decode
    // ************************************************************
    always_comb begin
        ctrl_hit  = 1'b0;
        op        = dmaef_pkg::DMAEF_OP_WRITE;
        ie_lane   = 1'b0;
        flag_lane = 1'b0;
        w_ie      = req.writedata[dmaef_pkg::IE_LSB +: dmaef_pkg::FIELD_W];
        w_flag    = req.writedata[dmaef_pkg::FLAG_LSB +: dmaef_pkg::FIELD_W];
        unique case (req.address)
            dmaef_pkg::OFF_CTRL: begin
                ctrl_hit = 1'b1;
                op       = dmaef_pkg::DMAEF_OP_WRITE;
            end
            dmaef_pkg::OFF_CLR: begin
                ctrl_hit = 1'b1;
                op       = dmaef_pkg::DMAEF_OP_CLR;
            end
            dmaef_pkg::OFF_SET: begin
                ctrl_hit = 1'b1;
                op       = dmaef_pkg::DMAEF_OP_SET;
            end
            dmaef_pkg::OFF_INV: begin
                ctrl_hit = 1'b1;
                op       = dmaef_pkg::DMAEF_OP_INV;
            end
            dmaef_pkg::OFF_ICLR: begin
                // write one to clear, low byte only
                op        = dmaef_pkg::DMAEF_OP_CLR;
                flag_lane = req.byteenable[0];
                w_flag    = req.writedata[7:0];
            end
            dmaef_pkg::OFF_IEN: begin
                op      = dmaef_pkg::DMAEF_OP_WRITE;
                ie_lane = req.byteenable[0];
                w_ie    = req.writedata[7:0];
            end
            default: begin
                ctrl_hit = 1'b0;
            end
        endcase
        if (ctrl_hit) begin
            // upper byte and byte 1 carry nothing, so their lanes are ignored
            ie_lane   = req.byteenable[2];
            flag_lane = req.byteenable[0];
        end
    end

    // ************************************************************
    // event detection
    // ************************************************************

    // a match is an event only on the cycle it becomes true, so a
    // pointer parked at the end does not re-flag after software clears
    assign src_done_hit = (source_pointer_i == source_size_i);
    assign src_half_hit = (source_pointer_i ==
                           (source_size_i >> 1));

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            src_done_seen <= 1'b1;
            src_half_seen <= 1'b1;
        end else begin
            src_done_seen <= src_done_hit;
            src_half_seen <= src_half_hit;
        end
    end

    assign src_done_evt = match_rise(src_done_hit, src_done_seen);
    assign src_half_evt = match_rise(src_half_hit, src_half_seen);

    always_comb begin
        hw_set                              = 8'h00;
        hw_set[dmaef_pkg::BIT_SRC_DONE]     = src_done_evt;
        hw_set[dmaef_pkg::BIT_SRC_HALF]     = src_half_evt;
        hw_set[dmaef_pkg::BIT_DST_DONE]     = evt_i.dst_done;
        hw_set[dmaef_pkg::BIT_DST_HALF]     = evt_i.dst_half;
        hw_set[dmaef_pkg::BIT_BLOCK_DONE]   = evt_i.block_done;
        hw_set[dmaef_pkg::BIT_CELL_DONE]    = evt_i.cell_done;
        hw_set[dmaef_pkg::BIT_ABORT]        = evt_i.abort;
        hw_set[dmaef_pkg::BIT_ADDR_ERR]     = evt_i.addr_err;
    end

    // ************************************************************
    // flags and enables
    // ************************************************************
    always_comb begin
        next_flags = flags;
        if (wr_take && flag_lane) begin
            next_flags = apply_op(flags, w_flag, op);
        end
        // a new event wins over a clear in the same cycle
        next_flags = next_flags | hw_set;
    end

    always_comb begin
        next_ie = ie;
        if (wr_take && ie_lane) begin
            next_ie = apply_op(ie, w_ie, op);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flags <= dmaef_pkg::RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ie <= dmaef_pkg::RST_IE;
        end else begin
            ie <= next_ie;
        end
    end

    // ************************************************************
    // interrupt request
    // ************************************************************

    // one term per event, taken from the next values so irq_o moves on the
    // same edge as the flag or enable that causes it
    assign src_done_pend       = armed(next_flags, next_ie, dmaef_pkg::BIT_SRC_DONE);
    assign src_half_pend       = armed(next_flags, next_ie, dmaef_pkg::BIT_SRC_HALF);
    assign dst_done_pend       = armed(next_flags, next_ie, dmaef_pkg::BIT_DST_DONE);
    assign dst_half_pend       = armed(next_flags, next_ie, dmaef_pkg::BIT_DST_HALF);
    assign block_complete_pend = armed(next_flags, next_ie, dmaef_pkg::BIT_BLOCK_DONE);
    assign cell_complete_pend  = armed(next_flags, next_ie, dmaef_pkg::BIT_CELL_DONE);
    assign abort_pend          = armed(next_flags, next_ie, dmaef_pkg::BIT_ABORT);
    assign addr_error_pend     = armed(next_flags, next_ie, dmaef_pkg::BIT_ADDR_ERR);

    // ************************************************************
    // request register
    // ************************************************************

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= src_done_pend
                   | src_half_pend
                   | dst_done_pend
                   | dst_half_pend
                   | block_complete_pend
                   | cell_complete_pend
                   | abort_pend
                   | addr_error_pend;
        end
    end

endmodule : dmaef_top

`default_nettype wire

// ===== sim/dmaef_chk.sv
// Purpose: port assertions of the channel event flag block
// Assumes: enables change only through 0x00 lane 2 and 0x18 lane 0
// Notes:   alias writes in the bench stay on lane 0
`timescale 1ns/1ps
`default_nettype none
module dmaef_chk #(
    parameter int SIZE_W = 16
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  srst_i,
    input  wire logic [4:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    input  wire logic [31:0]           avs_readdata_o,
    input  wire logic                  avs_waitrequest_o,
    input  wire logic [SIZE_W-1:0]     source_pointer_i,
    input  wire logic [SIZE_W-1:0]     source_size_i,
    input  wire dmaef_pkg::dmaef_evt_s evt_i,
    input  wire logic                  irq_o
);
    // ************************************************************
    // shadow of enables and of the source compares
    // ************************************************************
    logic [7:0] ie;
    logic       acc_wr;
    logic       eq_done;
    logic       eq_half;
    logic       was_done;
    logic       was_half;
    assign acc_wr  = avs_write_i && !avs_waitrequest_o;
    assign eq_done = source_pointer_i == source_size_i;
    assign eq_half = source_pointer_i == (source_size_i >> 1);
    always_ff @(posedge sys_clk_i) begin
        if (srst_i)
            ie <= 8'h00;
        else if (acc_wr && avs_address_i == 5'h00 && avs_byteenable_i[2])
            ie <= avs_writedata_i[23:16];
        else if (acc_wr && avs_address_i == 5'h18 && avs_byteenable_i[0])
            ie <= avs_writedata_i[7:0];
    end
    // reset counts as already equal, so no event fires on release
    always_ff @(posedge sys_clk_i) begin
        was_done <= srst_i | eq_done;
        was_half <= srst_i | eq_half;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait cycle count");
    a_unimpl_zero: assert property ((avs_readdata_o & 32'hFF00FF00) == 32'h0)
        else $error("reserved read bits set");
    a_evt_irq: assert property ((evt_i & ie[5:0]) != 6'h00 && !acc_wr |=> irq_o)
        else $error("enabled event gave no irq");
    a_src_done_irq: assert property (eq_done && !was_done && ie[7] && !acc_wr |=> irq_o)
        else $error("source done gave no irq");
    a_src_half_irq: assert property (eq_half && !was_half && ie[6] && !acc_wr |=> irq_o)
        else $error("source half gave no irq");
    a_irq_sticky: assert property (irq_o && !acc_wr |=> irq_o)
        else $error("irq dropped without write");
    a_irq_masked: assert property (ie == 8'h00 |-> !irq_o) else $error("irq with no enable");
    a_irq_cause: assert property (!irq_o && !acc_wr && evt_i == 6'h00 && !(eq_done && !was_done)
        && !(eq_half && !was_half) |=> !irq_o) else $error("irq without cause");
    c_irq_rise: cover property ($rose(irq_o));
    c_irq_clear: cover property (acc_wr && avs_address_i == 5'h14 && irq_o);
    c_half_hit: cover property (eq_half && !was_half);
endmodule : dmaef_chk
bind dmaef_top dmaef_chk #(.SIZE_W(SIZE_W)) dmaef_chk_inst (.sys_clk_i, .srst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .source_pointer_i, .source_size_i, .evt_i, .irq_o);
`default_nettype wire

// ===== sim/dmaef_chan_model.sv
// Purpose: transfer side of one channel: source pointer walk and event strobes
// Assumes: bench sets the walk target and size, and requests strobes
// Notes:   pointer moves one step a cycle toward the target
`timescale 1ns/1ps
`default_nettype none
module dmaef_chan_model #(
    parameter int SIZE_W = 16
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  srst_i,
    input  wire logic [SIZE_W-1:0]     target_i,
    input  wire logic [SIZE_W-1:0]     size_i,
    input  wire logic [5:0]            evt_req_i,
    output var  logic [SIZE_W-1:0]     source_pointer_o,
    output var  logic [SIZE_W-1:0]     source_size_o,
    output var  dmaef_pkg::dmaef_evt_s evt_o
);
    logic [5:0] last_req;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i)
            source_pointer_o <= '0;
        else if (source_pointer_o < target_i)
            source_pointer_o <= source_pointer_o + 1'b1;
        else if (source_pointer_o > target_i)
            source_pointer_o <= source_pointer_o - 1'b1;
    end
    always_ff @(posedge sys_clk_i) begin
        source_size_o <= size_i;
    end
    // strobes last one cycle however long the request is held
    always_ff @(posedge sys_clk_i) begin
        last_req <= evt_req_i;
        evt_o    <= srst_i ? 6'h00 : evt_req_i & ~last_req;
    end
endmodule : dmaef_chan_model
`default_nettype wire

// ===== sim/dmaef_top_tb.sv
// Purpose: self-checking bench of the channel event flag block
// Assumes: flags show one edge after a strobe
// Notes:   small SIZE_W keeps pointer walks short
`timescale 1ns/1ps
`default_nettype none
module dmaef_top_tb;
    localparam int SW = 8;
    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    logic [4:0]            addr = 5'h00;
    logic                  rd = 1'b0;
    logic                  wr = 1'b0;
    logic [31:0]           wdata = 32'h0;
    logic [3:0]            be = 4'h0;
    logic [31:0]           rdata;
    logic                  wait_o;
    logic [SW-1:0]         target = '0;
    logic [SW-1:0]         size = '0;
    logic [5:0]            evt_req = 6'h00;
    logic [SW-1:0]         ptr;
    logic [SW-1:0]         ssize;
    dmaef_pkg::dmaef_evt_s evt;
    logic                  irq;
    int                    err_total = 0;
    int                    compares = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    dmaef_top #(.SIZE_W(SW)) dmaef_top_inst (.sys_clk_i(clk), .srst_i(srst),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .source_pointer_i(ptr), .source_size_i(ssize), .evt_i(evt), .irq_o(irq));
    dmaef_chan_model #(.SIZE_W(SW)) dmaef_chan_model_inst (.sys_clk_i(clk), .srst_i(srst),
        .target_i(target), .size_i(size), .evt_req_i(evt_req), .source_pointer_o(ptr),
        .source_size_o(ssize), .evt_o(evt));
    // ************************************************************
    // bus and comparison tasks
    // ************************************************************
    task automatic complete_run;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        int n;
        n = 0;
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_o !== 1'b0) begin
            err_total++;
            complete_run();
        end
        @(posedge clk);
    endtask : bus
    task automatic wrw(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask : wrw
    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(nm, q, e);
    endtask : rdc
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        rdc("ctrl", 5'h00, 32'h0000_0000);
        wrw(5'h00, 32'hFFFF_FFFF, 4'hF);
        rdc("ctrl", 5'h00, 32'h00FF_00FF);
        chk("irq", {31'h0, irq}, 32'h1);
        wrw(5'h14, 32'h0000_00FF, 4'hF);
        chk("irq", {31'h0, irq}, 32'h0);
        rdc("iclr", 5'h14, 32'h0);
        wrw(5'h1C, 32'hFFFF_FFFF, 4'hF);
        rdc("unmapped", 5'h1C, 32'h0);
        rdc("ctrl", 5'h00, 32'h00FF_0000);
        wrw(5'h08, 32'h03, 4'h1);
        wrw(5'h04, 32'h01, 4'h1);
        wrw(5'h0C, 32'h05, 4'h1);
        rdc("status", 5'h10, 32'h07);
        wrw(5'h14, 32'hFF, 4'h1);
    endtask : t_regs
    // every other event enabled, so a crossed enable shows as irq
    task automatic t_events;
        for (int i = 0; i < 6; i++) begin
            wrw(5'h18, ~(32'h1 << i) & 32'hFF, 4'h1);
            evt_req <= 6'h01 << i;
            @(posedge clk);
            evt_req <= 6'h00;
            repeat (2) @(posedge clk);
            rdc("status", 5'h10, 32'h1 << i);
            chk("irq", {31'h0, irq}, 32'h0);
            wrw(5'h18, 32'h1 << i, 4'h1);
            chk("irq", {31'h0, irq}, 32'h1);
            rdc("ctrl", 5'h00, (32'h1 << (i + 16)) | (32'h1 << i));
            wrw(5'h14, 32'h1 << i, 4'h1);
            chk("irq", {31'h0, irq}, 32'h0);
        end
    endtask : t_events
    task automatic t_source;
        size <= SW'(9);
        repeat (3) @(posedge clk);
        wrw(5'h14, 32'hFF, 4'h1);
        wrw(5'h18, 32'hC0, 4'h1);
        target <= SW'(4);
        repeat (8) @(posedge clk);
        rdc("status", 5'h10, 32'h40);
        target <= SW'(9);
        repeat (8) @(posedge clk);
        rdc("status", 5'h10, 32'hC0);
        chk("irq", {31'h0, irq}, 32'h1);
        wrw(5'h14, 32'hC0, 4'h1);
        rdc("status", 5'h10, 32'h00);
        chk("irq", {31'h0, irq}, 32'h0);
    endtask : t_source
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_events();
        t_source();
        complete_run();
    end
endmodule : dmaef_top_tb
`default_nettype wire
